// file: design/rsap_pkg.sv
// rsap_pkg: register map, field layout, reset values and frame counts of the rx alarm bank
package rsap_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [7:0] OFS_MUX_CFG = 8'h90; // rx_mux_section_config
  localparam logic [7:0] OFS_PROT_BYTES = 8'h9C; // filtered_protection_bytes, k2 high k1 low
  localparam logic [7:0] OFS_MUX_STATUS = 8'hA0; // mux_section_status
  localparam logic [7:0] OFS_EVENT_LATCH = 8'hD0; // regen_event_latch, clears on read
  localparam logic [7:0] OFS_IRQ_MASK = 8'hD4; // rx_regen_interrupt_mask
  localparam logic [7:0] OFS_LIVE_STATUS = 8'hD8; // rx_regen_live_status
  localparam logic [7:0] OFS_EVENT_CLEAR = 8'hDC; // write-one-to-clear for the event latch
  // regenerator section bit positions
  localparam int BIT_FRAME_SLIP = 0;
  localparam int BIT_FRAME_LOSS = 1;
  localparam int BIT_CLOCK_LOCK = 2;
  localparam int BIT_SIGNAL_LOSS = 3;
  localparam int BIT_TRACE_CRC = 4;
  localparam int BIT_TRACE_MISMATCH = 5;
  localparam int BIT_TRACE_UNSETTLED = 6;
  localparam int BIT_PARITY_WRAP = 8;
  localparam int BIT_SLIP_WRAP = 9;
  // writable / readable masks of each register
  localparam logic [15:0] REGEN_USED = 16'h037F; // bits 9, 8, 6..0
  localparam logic [15:0] LIVE_USED = 16'h007F; // bits 6..0
  localparam logic [15:0] MUX_CFG_USED = 16'h2400; // bits 13 and 10
  // multiplexer section configuration and status fields
  localparam int BIT_FILTER_MODE = 13;
  localparam int BIT_PERSIST_SEL = 10;
  localparam int BIT_MS_ALARM = 0;
  // reset values
  localparam logic [15:0] RST_MUX_CFG = 16'h0400;
  localparam logic [15:0] RST_IRQ_MASK = 16'h0000;
  // frame persistence counts and the k2 alarm code
  localparam int PROT_STABLE_FRAMES = 3;
  localparam int MS_ALARM_SHORT = 3;
  localparam int MS_ALARM_LONG = 5;
  localparam logic [2:0] K2_AIS_CODE = 3'h7;
endpackage

// file: design/rsap_byte_filter.sv
// rsap_byte_filter: accepts a value once it has been identical for a number of frames
`timescale 1ns/1ns
`default_nettype none
module rsap_byte_filter #(
  parameter int WIDTH = 8,
  parameter int FRAMES = 3
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic frame_tick,
  input wire logic [WIDTH-1:0] value_in,
  output logic accept,
  output logic [WIDTH-1:0] accepted_value
);
  // candidate value and run length of identical frames
  logic [WIDTH-1:0] cand;
  logic [3:0] run;
  wire logic same = (value_in == cand);
  wire logic [3:0] run_inc = (run == 4'hF) ? run : run + 4'h1;
  wire logic reached = same && (run_inc >= 4'(FRAMES));

  // count identical frames, restart the run on any difference
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cand <= '0;
      run <= 4'h0;
      accept <= 1'b0;
      accepted_value <= '0;
    end else begin
      accept <= 1'b0;
      if (frame_tick) begin
        cand <= value_in;
        // a new value counts as the first frame of its run
        run <= same ? run_inc : 4'h1;
        if (reached) begin
          accept <= 1'b1;
          accepted_value <= cand;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: design/rsap_alarm_integ.sv
// rsap_alarm_integ: alarm that follows its input after a persistence of N frames
`timescale 1ns/1ns
`default_nettype none
module rsap_alarm_integ (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic frame_tick,
  input wire logic long_sel,
  input wire logic raw,
  output logic alarm
);
  // frames in a row that disagree with the present alarm state
  logic [2:0] run;
  wire logic [2:0] need = long_sel ? 3'(rsap_pkg::MS_ALARM_LONG) : 3'(rsap_pkg::MS_ALARM_SHORT);
  wire logic [2:0] run_inc = run + 3'h1;

  // set or clear only after the selected number of consecutive frames
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 3'h0;
      alarm <= 1'b0;
    end else if (frame_tick) begin
      if (raw == alarm) begin
        run <= 3'h0;
      end else if (run_inc >= need) begin
        alarm <= raw;
        run <= 3'h0;
      end else begin
        run <= run_inc;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/rsap_regs.sv
// rsap_regs: rx regenerator section alarm registers and protection byte filtering
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module rsap_regs (
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port
  input wire logic [rsap_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rsap_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rsap_pkg::DATA_W-1:0] reg_rdata,
  // raw regenerator section conditions from the detectors
  input wire logic trace_unsettled_in,
  input wire logic trace_mismatch_in,
  input wire logic trace_crc_in,
  input wire logic trace_16byte_mode,
  input wire logic signal_loss_in,
  input wire logic ext_sync_loss_input,
  input wire logic frame_loss_in,
  input wire logic framing_slip_in,
  input wire logic parity_counter_wrap,
  input wire logic frame_slip_counter_wrap,
  // receive frame timing and protection bytes
  input wire logic frame_tick,
  input wire logic [7:0] k1_in,
  input wire logic [7:0] k2_in,
  // results
  output logic [7:0] k1_filtered,
  output logic [7:0] k2_filtered,
  output logic ms_alarm_state,
  output logic irq
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  // multiplexer section configuration, only bits 13 and 10 are kept
  logic [15:0] rx_mux_section_config;
  // interrupt mask, one enable per event bit
  logic [15:0] rx_regen_interrupt_mask;
  // registered copy of the live conditions
  logic [15:0] rx_regen_live_status;
  // sticky change events
  logic [15:0] regen_event_latch;
  // stored protection bytes
  logic [15:0] filtered_protection_bytes;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // write strobes per register
  wire logic wr_mux_cfg = reg_wr && (reg_addr == rsap_pkg::OFS_MUX_CFG);
  wire logic wr_irq_mask = reg_wr && (reg_addr == rsap_pkg::OFS_IRQ_MASK);
  wire logic wr_event_clear = reg_wr && (reg_addr == rsap_pkg::OFS_EVENT_CLEAR);
  // read of the event latch clears it
  wire logic rd_event_latch = reg_rd && (reg_addr == rsap_pkg::OFS_EVENT_LATCH);

  // config fields steering the filters
  wire logic protection_filter_mode = rx_mux_section_config[rsap_pkg::BIT_FILTER_MODE];
  wire logic ms_alarm_persistence_sel = rx_mux_section_config[rsap_pkg::BIT_PERSIST_SEL];

  // ---------------------------------------------------------------
  // live status assembly
  // ---------------------------------------------------------------
  // crc7 check only means something with the 16-byte trace format
  wire logic trace_crc_state = trace_crc_in && trace_16byte_mode;
  // next live status word, unused positions held at zero
  logic [15:0] next_live;

  // place each condition at its bit position
  always_comb begin
    next_live = 16'h0000;
    next_live[rsap_pkg::BIT_TRACE_UNSETTLED] = trace_unsettled_in;
    next_live[rsap_pkg::BIT_TRACE_MISMATCH] = trace_mismatch_in;
    next_live[rsap_pkg::BIT_TRACE_CRC] = trace_crc_state;
    next_live[rsap_pkg::BIT_SIGNAL_LOSS] = signal_loss_in;
    next_live[rsap_pkg::BIT_CLOCK_LOCK] = ext_sync_loss_input;
    next_live[rsap_pkg::BIT_FRAME_LOSS] = frame_loss_in;
    next_live[rsap_pkg::BIT_FRAME_SLIP] = framing_slip_in;
  end

  // status tracks the inputs one cycle late
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_regen_live_status <= 16'h0000;
    end else begin
      rx_regen_live_status <= next_live;
    end
  end

  // ---------------------------------------------------------------
  // change events
  // ---------------------------------------------------------------
  // a change of any live bit, plus the counter wrap pulses
  logic [15:0] event_set;

  // collect the set terms of the event latch
  always_comb begin
    event_set = (next_live ^ rx_regen_live_status) & rsap_pkg::LIVE_USED;
    event_set[rsap_pkg::BIT_PARITY_WRAP] = parity_counter_wrap;
    event_set[rsap_pkg::BIT_SLIP_WRAP] = frame_slip_counter_wrap;
  end

  // clear terms: a read of the latch or a write-one-to-clear
  wire logic [15:0] event_clear = ({16{rd_event_latch}} |
                                   ({16{wr_event_clear}} & reg_wdata));
  // set wins over clear so an event in the clearing cycle survives
  wire logic [15:0] next_event = ((regen_event_latch & ~event_clear) | event_set) &
                                 rsap_pkg::REGEN_USED;

  // sticky event latch
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regen_event_latch <= 16'h0000;
    end else begin
      regen_event_latch <= next_event;
    end
  end

  // ---------------------------------------------------------------
  // software writable registers
  // ---------------------------------------------------------------
  // mask and configuration keep only their used bits
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_regen_interrupt_mask <= rsap_pkg::RST_IRQ_MASK;
      rx_mux_section_config <= rsap_pkg::RST_MUX_CFG;
    end else begin
      if (wr_irq_mask) begin
        rx_regen_interrupt_mask <= reg_wdata & rsap_pkg::REGEN_USED;
      end
      if (wr_mux_cfg) begin
        rx_mux_section_config <= reg_wdata & rsap_pkg::MUX_CFG_USED;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  // any enabled event bit, taken from the next latch value so the
  // output lines up with the latch register
  wire logic [15:0] next_mask = wr_irq_mask ? (reg_wdata & rsap_pkg::REGEN_USED) :
                                rx_regen_interrupt_mask;
  wire logic next_irq = |(next_event & next_mask);

  // level interrupt register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // protection byte filtering
  // ---------------------------------------------------------------
  // separate filters for each byte
  logic k1_accept;
  logic [7:0] k1_value;
  logic k2_accept;
  logic [7:0] k2_value;
  // joint filter for the pair
  logic pair_accept;
  logic [15:0] pair_value;

  // k1 alone
  rsap_byte_filter #(
    .WIDTH(8),
    .FRAMES(rsap_pkg::PROT_STABLE_FRAMES)
  ) u_k1_filter (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .frame_tick(frame_tick),
    .value_in(k1_in),
    .accept(k1_accept),
    .accepted_value(k1_value)
  );

  // k2 alone
  rsap_byte_filter #(
    .WIDTH(8),
    .FRAMES(rsap_pkg::PROT_STABLE_FRAMES)
  ) u_k2_filter (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .frame_tick(frame_tick),
    .value_in(k2_in),
    .accept(k2_accept),
    .accepted_value(k2_value)
  );

  // both bytes as one value
  rsap_byte_filter #(
    .WIDTH(16),
    .FRAMES(rsap_pkg::PROT_STABLE_FRAMES)
  ) u_pair_filter (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .frame_tick(frame_tick),
    .value_in({k2_in, k1_in}),
    .accept(pair_accept),
    .accepted_value(pair_value)
  );

  // next stored pair, chosen by the filter mode
  logic [15:0] next_prot;

  // joint mode moves both bytes at once, else each byte on its own
  always_comb begin
    next_prot = filtered_protection_bytes;
    if (protection_filter_mode) begin
      if (pair_accept) begin
        next_prot = pair_value;
      end
    end else begin
      if (k1_accept) begin
        next_prot[7:0] = k1_value;
      end
      if (k2_accept) begin
        next_prot[15:8] = k2_value;
      end
    end
  end

  // stored protection bytes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      filtered_protection_bytes <= 16'h0000;
      k1_filtered <= 8'h00;
      k2_filtered <= 8'h00;
    end else begin
      filtered_protection_bytes <= next_prot;
      k1_filtered <= next_prot[7:0];
      k2_filtered <= next_prot[15:8];
    end
  end

  // ---------------------------------------------------------------
  // multiplexer section alarm from the k2 rdi bits
  // ---------------------------------------------------------------
  // k2 bits 2..0 carry the rdi / ais code
  wire logic k2_ais_code = (k2_in[2:0] == rsap_pkg::K2_AIS_CODE);
  logic ms_alarm;

  // persistence of 5 frames when selected, else 3
  rsap_alarm_integ u_ms_alarm (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .frame_tick(frame_tick),
    .long_sel(ms_alarm_persistence_sel),
    .raw(k2_ais_code),
    .alarm(ms_alarm)
  );

  // alarm output register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_alarm_state <= 1'b0;
    end else begin
      ms_alarm_state <= ms_alarm;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // selected read word, unmapped offsets answer zero
  logic [15:0] next_rdata;

  // read multiplexer
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        rsap_pkg::OFS_MUX_CFG: next_rdata = rx_mux_section_config;
        rsap_pkg::OFS_PROT_BYTES: next_rdata = filtered_protection_bytes;
        rsap_pkg::OFS_MUX_STATUS: next_rdata[rsap_pkg::BIT_MS_ALARM] = ms_alarm_state;
        rsap_pkg::OFS_EVENT_LATCH: next_rdata = regen_event_latch;
        rsap_pkg::OFS_IRQ_MASK: next_rdata = rx_regen_interrupt_mask;
        rsap_pkg::OFS_LIVE_STATUS: next_rdata = rx_regen_live_status;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// file: tb/rsap_regs_assertions.sv
// rsap_regs_assertions: port-level checker for the rx alarm register bank
`timescale 1ns/1ns
`default_nettype none
module rsap_regs_assertions (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic trace_unsettled_in,
  input wire logic trace_mismatch_in,
  input wire logic trace_crc_in,
  input wire logic trace_16byte_mode,
  input wire logic signal_loss_in,
  input wire logic ext_sync_loss_input,
  input wire logic frame_loss_in,
  input wire logic framing_slip_in,
  input wire logic parity_counter_wrap,
  input wire logic frame_slip_counter_wrap,
  input wire logic frame_tick,
  input wire logic [7:0] k1_in,
  input wire logic [7:0] k2_in,
  input wire logic [7:0] k1_filtered,
  input wire logic [7:0] k2_filtered,
  input wire logic ms_alarm_state,
  input wire logic irq
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // raw conditions in live status bit order
  wire [6:0] live_raw = {trace_unsettled_in, trace_mismatch_in, trace_crc_in & trace_16byte_mode,
    signal_loss_in, ext_sync_loss_input, frame_loss_in, framing_slip_in};
  wire wraps = parity_counter_wrap | frame_slip_counter_wrap; // counter wrap events
  wire mask_wr = reg_wr && reg_addr == rsap_pkg::OFS_IRQ_MASK; // mask write
  wire ev_rd = reg_rd && reg_addr == rsap_pkg::OFS_EVENT_LATCH; // clearing read
  wire ais_now = k2_in[2:0] == rsap_pkg::K2_AIS_CODE; // alarm code in k2
  logic [2:0] k1_run, k2_run, kk_run, ais_run; // identical frames in a row, saturating
  logic [7:0] k1_prev, k2_prev; // bytes of the last frame
  logic ais_prev, pair_mode, long_sel; // last code, shadow of config bits
  wire [2:0] k1_need = pair_mode ? kk_run : k1_run; // run that gates k1
  wire [2:0] k2_need = pair_mode ? kk_run : k2_run; // run that gates k2
  // readable bits of each offset
  function automatic logic [15:0] used_bits(logic [7:0] a);
    case (a)
      rsap_pkg::OFS_MUX_CFG: return rsap_pkg::MUX_CFG_USED;
      rsap_pkg::OFS_IRQ_MASK, rsap_pkg::OFS_EVENT_LATCH: return rsap_pkg::REGEN_USED;
      rsap_pkg::OFS_LIVE_STATUS: return rsap_pkg::LIVE_USED;
      rsap_pkg::OFS_MUX_STATUS: return 16'h0001;
      rsap_pkg::OFS_PROT_BYTES, rsap_pkg::OFS_EVENT_CLEAR: return 16'hFFFF;
      default: return 16'h0000;
    endcase
  endfunction
  // advance a run count
  function automatic logic [2:0] bump(logic [2:0] r, logic same);
    return same ? r + {2'h0, r != 3'h7} : 3'h1;
  endfunction
  // frame run counters and config shadow
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      k1_run <= 3'h0;
      k2_run <= 3'h0;
      kk_run <= 3'h0;
      ais_run <= 3'h0;
      k1_prev <= 8'h00;
      k2_prev <= 8'h00;
      ais_prev <= 1'b0;
      pair_mode <= 1'b0;
      long_sel <= 1'b1;
    end else begin
      if (reg_wr && reg_addr == rsap_pkg::OFS_MUX_CFG) begin
        pair_mode <= reg_wdata[13];
        long_sel <= reg_wdata[10];
      end
      if (frame_tick) begin
        k1_run <= bump(k1_run, k1_in == k1_prev);
        k2_run <= bump(k2_run, k2_in == k2_prev);
        kk_run <= bump(kk_run, k1_in == k1_prev && k2_in == k2_prev);
        ais_run <= bump(ais_run, ais_now == ais_prev);
        k1_prev <= k1_in;
        k2_prev <= k2_in;
        ais_prev <= ais_now;
      end
    end
  end
  property p_live;
    reg_rd && reg_addr == rsap_pkg::OFS_LIVE_STATUS && $stable(live_raw)
      |=> reg_rdata == {9'h000, $past(live_raw)};
  endproperty
  property p_unused;
    reg_rd |=> (reg_rdata & ~used_bits($past(reg_addr))) == 16'h0000;
  endproperty
  property p_mask_off;
    mask_wr && reg_wdata == 16'h0000 |=> !irq;
  endproperty
  property p_irq_src;
    $rose(irq) |-> $past(live_raw) != $past(live_raw, 2) || $past(wraps) || $past(mask_wr);
  endproperty
  property p_ev_clear;
    ev_rd && $stable(live_raw) && !wraps ##1 $stable(live_raw) && !wraps ##1 ev_rd
      |=> reg_rdata == 16'h0000;
  endproperty
  property p_ms_tick;
    $changed(ms_alarm_state) |-> $past(frame_tick, 2) && ms_alarm_state == $past(ais_now, 2);
  endproperty
  property p_ms_run;
    $changed(ms_alarm_state) |-> $past(ais_run) >= (long_sel ? 3'h5 : 3'h3);
  endproperty
  property p_k1;
    $changed(k1_filtered) |-> $past(frame_tick, 2) && k1_filtered == $past(k1_in, 2)
      && $past(k1_need) >= 3'h3;
  endproperty
  property p_k2;
    $changed(k2_filtered) |-> $past(frame_tick, 2) && k2_filtered == $past(k2_in, 2)
      && $past(k2_need) >= 3'h3;
  endproperty
  a_live: assert property (p_live)
    else $error("live status read wrong");
  a_unused: assert property (p_unused)
    else $error("unused bits read nonzero");
  a_mask_off: assert property (p_mask_off)
    else $error("irq with all masks off");
  a_irq_src: assert property (p_irq_src)
    else $error("irq rose without cause");
  a_ev_clear: assert property (p_ev_clear)
    else $error("event latch not cleared by read");
  a_ms_tick: assert property (p_ms_tick)
    else $error("ms alarm moved off frame");
  a_ms_run: assert property (p_ms_run)
    else $error("ms alarm persistence short");
  a_k1: assert property (p_k1)
    else $error("k1 stored too early");
  a_k2: assert property (p_k2)
    else $error("k2 stored too early");
  c_ms: cover property ($rose(ms_alarm_state));
  c_k2: cover property ($changed(k2_filtered));
  c_irq: cover property ($fell(irq));
endmodule
bind rsap_regs rsap_regs_assertions chk_i (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .trace_unsettled_in, .trace_mismatch_in, .trace_crc_in,
  .trace_16byte_mode, .signal_loss_in, .ext_sync_loss_input, .frame_loss_in, .framing_slip_in,
  .parity_counter_wrap, .frame_slip_counter_wrap, .frame_tick, .k1_in, .k2_in, .k1_filtered,
  .k2_filtered, .ms_alarm_state, .irq);
`default_nettype wire

// file: tb/rsap_line_model.sv
// rsap_line_model: receive line source of frame ticks and protection bytes
`timescale 1ns/1ns
`default_nettype none
module rsap_line_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [7:0] k1_next,
  input wire logic [7:0] k2_next,
  output logic frame_tick,
  output logic [7:0] k1_in,
  output logic [7:0] k2_in
);
  logic [1:0] phase; // one frame every fourth cycle
  wire fire = run && phase == 2'h3; // frame boundary
  // bytes hold only with the tick and toggle in between
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
      frame_tick <= 1'b0;
      k1_in <= 8'h00;
      k2_in <= 8'h00;
    end else begin
      phase <= phase + 2'h1;
      frame_tick <= fire;
      k1_in <= fire ? k1_next : ~k1_in;
      k2_in <= fire ? k2_next : ~k2_in;
    end
  end
endmodule
`default_nettype wire

// file: tb/rsap_regs_test.sv
// rsap_regs_test: self-checking bench for the rx alarm register bank
`timescale 1ns/1ns
`default_nettype none
module rsap_regs_test;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] raw = 7'h00; // raw conditions in status bit order
  logic mode16 = 1'b1; // 16-byte trace format
  logic pwrap = 1'b0;
  logic swrap = 1'b0;
  logic run = 1'b0; // frames flowing
  logic [7:0] k1n = 8'h00;
  logic [7:0] k2n = 8'h00;
  logic [15:0] reg_rdata, b, r;
  logic [7:0] k1_in, k2_in, k1_f, k2_f, ka, kb;
  logic frame_tick, ms, irq, rd_pend = 1'b0;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 32'h30EA;
  logic [15:0] exp_q[$]; // expected read words, oldest first
  always #4 sys_clk = ~sys_clk;
  rsap_line_model line (.sys_clk(sys_clk), .arst_n(arst_n), .run(run), .k1_next(k1n),
    .k2_next(k2n), .frame_tick(frame_tick), .k1_in(k1_in), .k2_in(k2_in));
  rsap_regs uut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trace_unsettled_in(raw[6]), .trace_mismatch_in(raw[5]), .trace_crc_in(raw[4]),
    .trace_16byte_mode(mode16), .signal_loss_in(raw[3]), .ext_sync_loss_input(raw[2]),
    .frame_loss_in(raw[1]), .framing_slip_in(raw[0]), .parity_counter_wrap(pwrap),
    .frame_slip_counter_wrap(swrap), .frame_tick(frame_tick), .k1_in(k1_in), .k2_in(k2_in),
    .k1_filtered(k1_f), .k2_filtered(k2_f), .ms_alarm_state(ms), .irq(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    tests_run++;
    if (got !== want) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // returned read word against the oldest note
  always @(posedge sys_clk) begin
    if (rd_pend) chk(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  // hold bytes for n frames, bounded wait per frame
  task automatic frames(input logic [7:0] a, input logic [7:0] c, input int n);
    int w;
    k1n <= a;
    k2n <= c;
    repeat (n) begin
      w = 0;
      @(posedge sys_clk);
      while (frame_tick !== 1'b1) begin
        w++;
        if (w > 20) begin
          chk(16'h0000, 16'h0001);
          report_and_stop;
        end
        @(posedge sys_clk);
      end
    end
  endtask
  initial begin
    idle(16);
    arst_n <= 1'b1;
    rd(8'h90, 16'h0400);
    rd(8'hD4, 16'h0000);
    rd(8'h10, 16'h0000);
    wr(8'h90, 16'hFFFF);
    rd(8'h90, 16'h2400);
    wr(8'hD4, 16'hFFFF);
    rd(8'hD4, 16'h037F);
    wr(8'hD8, 16'hFFFF);
    rd(8'hD8, 16'h0000);
    // each condition raised and dropped, events latched and cleared
    for (int i = 0; i < 7; i++) begin
      b = 16'h0001 << i;
      raw[i] <= 1'b1;
      idle(3);
      chk({15'h0000, irq}, 16'h0001);
      rd(8'hD8, b);
      rd(8'hD0, b);
      rd(8'hD0, 16'h0000);
      idle(1);
      chk({15'h0000, irq}, 16'h0000);
      raw[i] <= 1'b0;
      idle(3);
      rd(8'hD0, b);
      rd(8'hD8, 16'h0000);
    end
    mode16 <= 1'b0;
    raw[4] <= 1'b1;
    idle(3);
    rd(8'hD8, 16'h0000);
    raw[4] <= 1'b0;
    mode16 <= 1'b1;
    wr(8'hD4, 16'h0000);
    raw[2] <= 1'b1;
    idle(3);
    chk({15'h0000, irq}, 16'h0000);
    wr(8'hD4, 16'h0004);
    idle(1);
    chk({15'h0000, irq}, 16'h0001);
    pwrap <= 1'b1;
    idle(1);
    pwrap <= 1'b0;
    swrap <= 1'b1;
    idle(1);
    swrap <= 1'b0;
    rd(8'hD0, 16'h0304);
    idle(1);
    chk({15'h0000, irq}, 16'h0000);
    // paired filtering: k2 never settles, then both settle
    r = 16'($random(seed));
    ka = r[7:0] | 8'h01;
    kb = r[15:8] & 8'hF0;
    run <= 1'b1;
    for (int i = 0; i < 4; i++) frames(ka, kb + 8'(i), 1);
    idle(4);
    chk({k2_f, k1_f}, 16'h0000);
    frames(ka, kb, 3);
    idle(4);
    rd(rsap_pkg::OFS_PROT_BYTES, {kb, ka});
    // separate filtering, short then long persistence
    wr(8'h90, 16'h0000);
    frames(ka ^ 8'h3C, kb, 2);
    for (int i = 1; i < 4; i++) frames(~ka, kb + 8'(i), 1);
    idle(4);
    chk({k2_f, k1_f}, {kb, ~ka});
    frames(~ka, 8'h07, 2);
    idle(2);
    chk({15'h0000, ms}, 16'h0000);
    frames(~ka, 8'h07, 1);
    idle(2);
    chk({15'h0000, ms}, 16'h0001);
    rd(rsap_pkg::OFS_MUX_STATUS, 16'h0001);
    wr(8'h90, 16'h0400);
    frames(~ka, 8'h00, 4);
    idle(2);
    chk({15'h0000, ms}, 16'h0001);
    frames(~ka, 8'h00, 1);
    idle(2);
    chk({15'h0000, ms}, 16'h0000);
    idle(4);
    report_and_stop;
  end
endmodule
`default_nettype wire
